// [mlic_consts.svh]
// Purpose: constants of the multi-level interrupt controller
// Assumes: word addressed program memory, 17-bit program counter
// Notes: Contract list below
//
// Contract
// [R1] Each peripheral request is tagged with one of three levels: high, medium or low.
// [R2] A pending medium request preempts a running low level routine.
// [R3] A pending high request preempts a running low or medium level routine.
// [R4] Low requests are arbitrated by fixed priority or by selectable round-robin.
// [R5] Oscillator failure raises a non-maskable request with its own vector at word 0x002.
// [R6] Every distinct interrupt owns its own vector address.
// [R7] The vector is the peripheral base plus the per-interrupt offset, in words.
// [R8] On acceptance the core's program counter is loaded with the vector.
// [R9] The whole vector table can be moved to the start of the boot section.
// [R10] Port C base is 0x004, port R base 0x008, DMA base 0x00C.
// [R11] 32-bit counter base is 0x014, two-wire C base 0x018, timer C0 base 0x01C.
// [R12] Fixed vectors: SPI C at 0x030, cipher engine at 0x03E, SPI D at 0x0AE.
// [R13] Nonvolatile base is 0x040, port D base 0x080, serial F0 base 0x0EE.
// [R14] A request never preempts a routine of the same or a higher level.
`ifndef MLIC_CONSTS_SVH
`define MLIC_CONSTS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define MLIC_NSRC 12
`define MLIC_VW 17
`define MLIC_OFFW 4
`define MLIC_OFF_SPAN 17'h00010
`define MLIC_BOOT_BASE 17'h10000

// ----------------------------------------------------------------
// level request codes and active-level indices
// ----------------------------------------------------------------
`define MLIC_REQ_LOW 2'h1
`define MLIC_REQ_MED 2'h2
`define MLIC_REQ_HIGH 2'h3
`define MLIC_ACT_LOW 2'h0
`define MLIC_ACT_MED 2'h1
`define MLIC_ACT_HIGH 2'h2
`define MLIC_ACT_NMI 2'h3

// ----------------------------------------------------------------
// source indices
// ----------------------------------------------------------------
`define MLIC_SRC_PORT_C 4'h0
`define MLIC_SRC_PORT_R 4'h1
`define MLIC_SRC_DMA 4'h2
`define MLIC_SRC_CNT32 4'h3
`define MLIC_SRC_TWI_C 4'h4
`define MLIC_SRC_TMR_C0 4'h5
`define MLIC_SRC_SPI_C 4'h6
`define MLIC_SRC_CIPHER 4'h7
`define MLIC_SRC_NVM 4'h8
`define MLIC_SRC_PORT_D 4'h9
`define MLIC_SRC_SPI_D 4'hA
`define MLIC_SRC_SER_F0 4'hB

// ----------------------------------------------------------------
// vector map, word addresses
// ----------------------------------------------------------------
`define MLIC_OSC_FAILURE_VECTOR 17'h00002
`define MLIC_PORT_C_IRQ_BASE 17'h00004
`define MLIC_PORT_R_IRQ_BASE 17'h00008
`define MLIC_DMA_IRQ_BASE 17'h0000C
`define MLIC_COUNTER32_IRQ_BASE 17'h00014
`define MLIC_TWOWIRE_C_IRQ_BASE 17'h00018
`define MLIC_TIMER_C0_IRQ_BASE 17'h0001C
`define MLIC_SPI_C_VECTOR 17'h00030
`define MLIC_CIPHER_VECTOR 17'h0003E
`define MLIC_NONVOLATILE_IRQ_BASE 17'h00040
`define MLIC_PORT_D_IRQ_BASE 17'h00080
`define MLIC_SPI_D_VECTOR 17'h000AE
`define MLIC_SERIAL_F0_IRQ_BASE 17'h000EE

`endif

// [mlic_pkg.sv]
// Purpose: types of the multi-level interrupt controller
// Assumes: constants come from mlic_consts.svh
// Notes: widths only, no logic
`include "mlic_consts.svh"

package mlic_pkg;
  typedef logic [`MLIC_VW-1:0] mlic_vec_t;
  typedef logic [`MLIC_NSRC-1:0] mlic_req_t;
  typedef logic [2*`MLIC_NSRC-1:0] mlic_lvlcfg_t;
  typedef logic [`MLIC_OFFW*`MLIC_NSRC-1:0] mlic_offs_t;
  typedef logic [3:0] mlic_src_t;
  typedef logic [1:0] mlic_act_t;
endpackage : mlic_pkg

// [mlic_multi_level_irq_controller.sv]
// Purpose: three-level nested interrupt controller with NMI and vector generation
// Assumes: core pulses CORE_ACK to take the presented vector, CORE_RETI on return
// Notes: requests stay high until the peripheral clears them in its routine
`timescale 1ns/10ps
`include "mlic_consts.svh"

module mlic_multi_level_irq_controller (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire mlic_pkg::mlic_req_t IRQ_REQ,
  input wire mlic_pkg::mlic_lvlcfg_t IRQ_LEVEL,
  input wire mlic_pkg::mlic_offs_t IRQ_OFFSET,
  input wire logic [2:0] LEVEL_EN,
  input wire logic RR_EN,
  input wire logic BOOT_VECT_SEL,
  input wire logic OSC_FAIL,
  input wire logic CORE_ACK,
  input wire logic CORE_RETI,
  output logic IRQ_VALID,
  output mlic_pkg::mlic_vec_t IRQ_VECTOR,
  output mlic_pkg::mlic_act_t IRQ_ACT_LEVEL,
  output mlic_pkg::mlic_src_t IRQ_SRC,
  output logic [3:0] ACTIVE_LEVELS
);
  import mlic_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic osc_meta_reg, osc_sync_reg, osc_prev_reg;
  logic nmi_pend_reg;
  logic [3:0] active_reg, active_next;
  mlic_src_t rr_ptr_reg;
  logic valid_reg, valid_next;
  mlic_vec_t vector_reg, vector_next;
  mlic_act_t lvl_reg, lvl_next;
  mlic_src_t src_reg, src_next;
  logic hi_hit, med_hit, low_hit;
  mlic_src_t hi_src, med_src, low_src;
  logic take;
  int j;

  // base address of each source
  function automatic mlic_vec_t base_of(input mlic_src_t s);
    mlic_vec_t b;
    unique case (s) // one entry per source, no shared vector [R6]
      `MLIC_SRC_PORT_C: b = `MLIC_PORT_C_IRQ_BASE; // [R10]
      `MLIC_SRC_PORT_R: b = `MLIC_PORT_R_IRQ_BASE; // [R10]
      `MLIC_SRC_DMA: b = `MLIC_DMA_IRQ_BASE; // [R10]
      `MLIC_SRC_CNT32: b = `MLIC_COUNTER32_IRQ_BASE; // [R11]
      `MLIC_SRC_TWI_C: b = `MLIC_TWOWIRE_C_IRQ_BASE; // [R11]
      `MLIC_SRC_TMR_C0: b = `MLIC_TIMER_C0_IRQ_BASE; // [R11]
      `MLIC_SRC_SPI_C: b = `MLIC_SPI_C_VECTOR; // [R12]
      `MLIC_SRC_CIPHER: b = `MLIC_CIPHER_VECTOR; // [R12]
      `MLIC_SRC_NVM: b = `MLIC_NONVOLATILE_IRQ_BASE; // [R13]
      `MLIC_SRC_PORT_D: b = `MLIC_PORT_D_IRQ_BASE; // [R13]
      `MLIC_SRC_SPI_D: b = `MLIC_SPI_D_VECTOR; // [R12]
      `MLIC_SRC_SER_F0: b = `MLIC_SERIAL_F0_IRQ_BASE; // [R13]
      default: b = '0;
    endcase
    return b;
  endfunction : base_of

  // single-vector sources ignore their offset
  function automatic logic single_vec(input mlic_src_t s);
    return (s == `MLIC_SRC_SPI_C) || (s == `MLIC_SRC_CIPHER) || (s == `MLIC_SRC_SPI_D);
  endfunction : single_vec

  // table start, zero or boot section
  function automatic mlic_vec_t table_base(input logic boot);
    return boot ? `MLIC_BOOT_BASE : '0; // [R9]
  endfunction : table_base

  // full vector of a maskable source
  function automatic mlic_vec_t vec_of(input mlic_src_t s, input logic boot,
                                       input mlic_offs_t offs);
    mlic_vec_t o;
    o = single_vec(s) ? '0 : mlic_vec_t'(offs[`MLIC_OFFW*s +: `MLIC_OFFW]);
    return mlic_vec_t'(table_base(boot) + base_of(s) + o); // [R7]
  endfunction : vec_of

  // ----------------------------------------------------------------
  // oscillator failure synchroniser and sticky NMI
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= OSC_FAIL;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // new failure wins over the clear by acceptance
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      nmi_pend_reg <= 1'b0;
    end else if (osc_sync_reg && !osc_prev_reg) begin
      nmi_pend_reg <= 1'b1; // [R5]
    end else if (take && lvl_reg == `MLIC_ACT_NMI) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-level winners
  // ----------------------------------------------------------------
  always_comb begin
    hi_hit = 1'b0;
    med_hit = 1'b0;
    low_hit = 1'b0;
    hi_src = '0;
    med_src = '0;
    low_src = '0;
    j = 0;
    // fixed priority, lowest index wins
    for (int i = `MLIC_NSRC - 1; i >= 0; i--) begin
      if (IRQ_REQ[i] && IRQ_LEVEL[2*i +: 2] == `MLIC_REQ_HIGH) begin // [R1]
        hi_hit = 1'b1;
        hi_src = mlic_src_t'(i);
      end
      if (IRQ_REQ[i] && IRQ_LEVEL[2*i +: 2] == `MLIC_REQ_MED) begin // [R1]
        med_hit = 1'b1;
        med_src = mlic_src_t'(i);
      end
    end
    // low level: search starts at the round-robin pointer when enabled
    for (int k = `MLIC_NSRC - 1; k >= 0; k--) begin
      j = (RR_EN ? int'(rr_ptr_reg) : 0) + k;
      if (j >= `MLIC_NSRC) begin
        j = j - `MLIC_NSRC;
      end
      if (IRQ_REQ[j] && IRQ_LEVEL[2*j +: 2] == `MLIC_REQ_LOW) begin // [R1] [R4]
        low_hit = 1'b1;
        low_src = mlic_src_t'(j);
      end
    end
  end

  // ----------------------------------------------------------------
  // selection against the running levels
  // ----------------------------------------------------------------
  assign take = CORE_ACK && valid_reg;

  always_comb begin
    valid_next = 1'b0;
    vector_next = vector_reg;
    lvl_next = lvl_reg;
    src_next = src_reg;
    if (take) begin
      valid_next = 1'b0; // re-evaluate once the new level is running
    end else if (nmi_pend_reg && !active_reg[3]) begin
      valid_next = 1'b1; // level enables do not gate it [R5]
      vector_next = mlic_vec_t'(table_base(BOOT_VECT_SEL) + `MLIC_OSC_FAILURE_VECTOR);
      lvl_next = `MLIC_ACT_NMI;
      src_next = '0;
    end else if (hi_hit && LEVEL_EN[2] && active_reg[3:2] == 2'h0) begin // [R3] [R14]
      valid_next = 1'b1;
      vector_next = vec_of(hi_src, BOOT_VECT_SEL, IRQ_OFFSET);
      lvl_next = `MLIC_ACT_HIGH;
      src_next = hi_src;
    end else if (med_hit && LEVEL_EN[1] && active_reg[3:1] == 3'h0) begin // [R2] [R14]
      valid_next = 1'b1;
      vector_next = vec_of(med_src, BOOT_VECT_SEL, IRQ_OFFSET);
      lvl_next = `MLIC_ACT_MED;
      src_next = med_src;
    end else if (low_hit && LEVEL_EN[0] && active_reg == 4'h0) begin // [R14]
      valid_next = 1'b1;
      vector_next = vec_of(low_src, BOOT_VECT_SEL, IRQ_OFFSET);
      lvl_next = `MLIC_ACT_LOW;
      src_next = low_src;
    end
  end

  // presented vector for the core's program counter
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      valid_reg <= 1'b0;
      vector_reg <= '0;
      lvl_reg <= `MLIC_ACT_LOW;
      src_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      vector_reg <= vector_next; // [R8]
      lvl_reg <= lvl_next;
      src_reg <= src_next;
    end
  end

  // ----------------------------------------------------------------
  // running levels: return clears the top one, acceptance sets one
  // ----------------------------------------------------------------
  always_comb begin
    active_next = active_reg;
    if (CORE_RETI) begin
      if (active_reg[3]) begin
        active_next[3] = 1'b0;
      end else if (active_reg[2]) begin
        active_next[2] = 1'b0;
      end else if (active_reg[1]) begin
        active_next[1] = 1'b0;
      end else begin
        active_next[0] = 1'b0;
      end
    end
    if (take) begin
      active_next[lvl_reg] = 1'b1; // [R8]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      active_reg <= 4'h0;
    end else begin
      active_reg <= active_next;
    end
  end

  // round-robin pointer moves past the last low source served
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rr_ptr_reg <= '0;
    end else if (take && lvl_reg == `MLIC_ACT_LOW && RR_EN) begin
      rr_ptr_reg <= (src_reg == mlic_src_t'(`MLIC_NSRC - 1)) ? '0 : mlic_src_t'(src_reg + 1); // [R4]
    end
  end

  // outputs
  assign IRQ_VALID = valid_reg;
  assign IRQ_VECTOR = vector_reg;
  assign IRQ_ACT_LEVEL = lvl_reg;
  assign IRQ_SRC = src_reg;
  assign ACTIVE_LEVELS = active_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_nmi_vector;
    @(posedge CORE_CLK) disable iff (!RST_B)
      valid_reg && lvl_reg == `MLIC_ACT_NMI |->
        vector_reg == mlic_vec_t'(table_base($past(BOOT_VECT_SEL)) + `MLIC_OSC_FAILURE_VECTOR);
  endproperty
  a_nmi_vector: assert property (p_nmi_vector) else $error("bad NMI vector"); // [R5]

  property p_nmi_unmasked;
    @(posedge CORE_CLK) disable iff (!RST_B)
      nmi_pend_reg && !active_reg[3] && !take |=> valid_reg && lvl_reg == `MLIC_ACT_NMI;
  endproperty
  a_nmi_unmasked: assert property (p_nmi_unmasked) else $error("NMI not presented"); // [R5]

  property p_high_preempts;
    @(posedge CORE_CLK) disable iff (!RST_B)
      hi_hit && LEVEL_EN[2] && active_reg[3:2] == 2'h0 && active_reg[1:0] != 2'h0
        && !nmi_pend_reg && !take |=> valid_reg && lvl_reg == `MLIC_ACT_HIGH;
  endproperty
  a_high_preempts: assert property (p_high_preempts) else $error("high did not preempt"); // [R3]

  property p_med_preempts;
    @(posedge CORE_CLK) disable iff (!RST_B)
      med_hit && !hi_hit && LEVEL_EN[1] && active_reg == 4'h1 && !nmi_pend_reg && !take
        |=> valid_reg && lvl_reg == `MLIC_ACT_MED;
  endproperty
  a_med_preempts: assert property (p_med_preempts) else $error("medium did not preempt"); // [R2]

  property p_no_equal_preempt;
    @(posedge CORE_CLK) disable iff (!RST_B)
      valid_reg |-> (active_reg >> lvl_reg) == 4'h0 || $past(CORE_RETI);
  endproperty
  a_no_equal_preempt: assert property (p_no_equal_preempt) else $error("same level preempt"); // [R14]

  property p_vector_sum;
    @(posedge CORE_CLK) disable iff (!RST_B)
      valid_reg && lvl_reg != `MLIC_ACT_NMI |->
        vector_reg == vec_of(src_reg, $past(BOOT_VECT_SEL), $past(IRQ_OFFSET));
  endproperty
  a_vector_sum: assert property (p_vector_sum) else $error("vector not base plus offset"); // [R7]

  property p_accept_level;
    @(posedge CORE_CLK) disable iff (!RST_B)
      take && !CORE_RETI |=> active_reg[$past(lvl_reg)] && !valid_reg;
  endproperty
  a_accept_level: assert property (p_accept_level) else $error("acceptance not recorded"); // [R8]

  property p_rr_advance;
    @(posedge CORE_CLK) disable iff (!RST_B)
      take && lvl_reg == `MLIC_ACT_LOW && RR_EN && src_reg == `MLIC_SRC_PORT_C
        |=> rr_ptr_reg == `MLIC_SRC_PORT_R;
  endproperty
  a_rr_advance: assert property (p_rr_advance) else $error("round-robin did not advance"); // [R4]

  property p_port_c_base;
    @(posedge CORE_CLK) disable iff (!RST_B)
      valid_reg && src_reg == `MLIC_SRC_PORT_C && lvl_reg != `MLIC_ACT_NMI && !$past(BOOT_VECT_SEL)
        |-> vector_reg >= `MLIC_PORT_C_IRQ_BASE
          && vector_reg < `MLIC_PORT_C_IRQ_BASE + `MLIC_OFF_SPAN;
  endproperty
  a_port_c_base: assert property (p_port_c_base) else $error("port C vector out of range"); // [R10]

endmodule : mlic_multi_level_irq_controller

// [mlic_core_model.sv]
// Purpose: behavioural core on the far side of the interrupt controller
// Assumes: vector taken with a one-cycle ack pulse, return with a one-cycle pulse
// Notes: ack delay is set by ack_wait, zero answers promptly
`timescale 1ns/10ps

module mlic_core_model (
  input wire logic clk,
  input wire logic irq_valid,
  input wire mlic_pkg::mlic_vec_t irq_vector,
  input wire mlic_pkg::mlic_act_t irq_act,
  input wire mlic_pkg::mlic_src_t irq_src,
  input wire logic [3:0] ack_wait,
  output logic core_ack,
  output logic core_reti,
  output mlic_pkg::mlic_vec_t pc,
  output mlic_pkg::mlic_act_t act_seen,
  output mlic_pkg::mlic_src_t src_seen,
  output int n_taken
);
  import mlic_pkg::*;
  logic [3:0] wait_cnt;

  initial begin
    core_ack = 1'b0;
    core_reti = 1'b0;
    pc = '0;
    act_seen = '0;
    src_seen = '0;
    n_taken = 0;
    wait_cnt = 4'h0;
  end

  // ack after ack_wait cycles of a presented vector, driven off the sampling edge
  always @(negedge clk) begin
    core_ack <= 1'b0;
    if (irq_valid === 1'b1 && !core_ack) begin
      if (wait_cnt >= ack_wait) begin
        core_ack <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else if (irq_valid !== 1'b1) begin
      wait_cnt <= 4'h0;
    end
  end

  // program counter loaded with the vector taken at the ack edge
  always @(posedge clk) begin
    if (core_ack && irq_valid === 1'b1) begin
      pc <= irq_vector;
      act_seen <= irq_act;
      src_seen <= irq_src;
      n_taken <= n_taken + 1;
    end
  end

  // return from the running routine, one-cycle pulse
  task automatic do_return();
    @(negedge clk);
    core_reti <= 1'b1;
    @(negedge clk);
    core_reti <= 1'b0;
  endtask : do_return
endmodule : mlic_core_model

// [tb_top.sv]
// Purpose: self-checking bench of the multi-level interrupt controller
// Assumes: inputs driven at the falling edge, core model takes vectors
// Notes: source i uses offset i mod 3 plus 1, single-vector sources ignore it
`timescale 1ns/10ps
`include "mlic_consts.svh"

module tb_top;
  import mlic_pkg::*;
  logic CORE_CLK, RST_B, RR_EN, BOOT_VECT_SEL, OSC_FAIL, CORE_ACK, CORE_RETI, IRQ_VALID;
  mlic_req_t IRQ_REQ;
  mlic_lvlcfg_t IRQ_LEVEL;
  mlic_offs_t IRQ_OFFSET;
  logic [2:0] LEVEL_EN;
  logic [3:0] ACTIVE_LEVELS, ack_wait;
  mlic_vec_t IRQ_VECTOR, pc;
  mlic_act_t IRQ_ACT_LEVEL, act_seen;
  mlic_src_t IRQ_SRC, src_seen;
  int n_taken, n_errors, n_compared;
  localparam mlic_vec_t BASES [12] = '{`MLIC_PORT_C_IRQ_BASE, `MLIC_PORT_R_IRQ_BASE,
    `MLIC_DMA_IRQ_BASE, `MLIC_COUNTER32_IRQ_BASE, `MLIC_TWOWIRE_C_IRQ_BASE,
    `MLIC_TIMER_C0_IRQ_BASE, `MLIC_SPI_C_VECTOR, `MLIC_CIPHER_VECTOR,
    `MLIC_NONVOLATILE_IRQ_BASE, `MLIC_PORT_D_IRQ_BASE, `MLIC_SPI_D_VECTOR,
    `MLIC_SERIAL_F0_IRQ_BASE};

  mlic_multi_level_irq_controller i_mlic_multi_level_irq_controller (.CORE_CLK(CORE_CLK),
    .RST_B(RST_B), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_OFFSET(IRQ_OFFSET),
    .LEVEL_EN(LEVEL_EN), .RR_EN(RR_EN), .BOOT_VECT_SEL(BOOT_VECT_SEL), .OSC_FAIL(OSC_FAIL),
    .CORE_ACK(CORE_ACK), .CORE_RETI(CORE_RETI), .IRQ_VALID(IRQ_VALID),
    .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ACT_LEVEL(IRQ_ACT_LEVEL), .IRQ_SRC(IRQ_SRC),
    .ACTIVE_LEVELS(ACTIVE_LEVELS));

  mlic_core_model i_mlic_core_model (.clk(CORE_CLK), .irq_valid(IRQ_VALID),
    .irq_vector(IRQ_VECTOR), .irq_act(IRQ_ACT_LEVEL), .irq_src(IRQ_SRC),
    .ack_wait(ack_wait), .core_ack(CORE_ACK), .core_reti(CORE_RETI), .pc(pc),
    .act_seen(act_seen), .src_seen(src_seen), .n_taken(n_taken));

  // 25 MHz clock
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk

  function automatic mlic_vec_t ev(input int i, input logic boot);
    ev = BASES[i] + ((i == 6 || i == 7 || i == 10) ? 17'h00000 : mlic_vec_t'(i % 3 + 1))
      + (boot ? `MLIC_BOOT_BASE : 17'h00000);
  endfunction : ev

  task automatic set_req(input int i, input logic [1:0] lvl, input logic on);
    @(negedge CORE_CLK);
    IRQ_REQ[i] = on;
    IRQ_LEVEL[2*i +: 2] = lvl;
  endtask : set_req

  // wait for the core to take a vector, then judge it
  task automatic take(input mlic_vec_t v, input mlic_act_t a, input mlic_src_t s);
    int n0;
    int k;
    n0 = n_taken;
    k = 0;
    while (n_taken == n0 && k < 20) begin
      @(negedge CORE_CLK);
      k++;
    end
    chk(n_taken != n0, "no vector taken");
    chk(pc === v, "vector value");
    chk(act_seen === a, "presented level");
    chk(src_seen === s, "presented source");
  endtask : take

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge CORE_CLK);
      chk(IRQ_VALID === 1'b0, "vector presented while blocked");
    end
  endtask : quiet

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_vectors();
    for (int b = 0; b < 2; b++) begin
      BOOT_VECT_SEL = b[0];
      ack_wait = b ? 4'h3 : 4'h0;
      for (int i = 0; i < 12; i++) begin
        set_req(i, 2'h3, 1'b1);
        take(ev(i, b[0]), `MLIC_ACT_HIGH, i[3:0]);
        set_req(i, 2'h0, 1'b0);
        i_mlic_core_model.do_return();
      end
    end
    BOOT_VECT_SEL = 1'b0;
    ack_wait = 4'h0;
  endtask : t_vectors

  task automatic t_round_robin();
    RR_EN = 1'b1;
    set_req(0, 2'h1, 1'b1);
    set_req(1, 2'h1, 1'b1);
    take(ev(0, 1'b0), `MLIC_ACT_LOW, 4'h0);
    i_mlic_core_model.do_return();
    take(ev(1, 1'b0), `MLIC_ACT_LOW, 4'h1);
    i_mlic_core_model.do_return();
    take(ev(0, 1'b0), `MLIC_ACT_LOW, 4'h0);
    i_mlic_core_model.do_return();
    RR_EN = 1'b0;
    take(ev(0, 1'b0), `MLIC_ACT_LOW, 4'h0);
    set_req(0, 2'h0, 1'b0);
    set_req(1, 2'h0, 1'b0);
    i_mlic_core_model.do_return();
  endtask : t_round_robin

  task automatic t_preempt();
    set_req(0, 2'h1, 1'b1);
    take(ev(0, 1'b0), `MLIC_ACT_LOW, 4'h0);
    set_req(0, 2'h0, 1'b0);
    set_req(1, 2'h2, 1'b1);
    take(ev(1, 1'b0), `MLIC_ACT_MED, 4'h1);
    set_req(1, 2'h0, 1'b0);
    set_req(2, 2'h3, 1'b1);
    take(ev(2, 1'b0), `MLIC_ACT_HIGH, 4'h2);
    set_req(2, 2'h0, 1'b0);
    chk(ACTIVE_LEVELS === 4'h7, "nested levels");
    set_req(3, 2'h3, 1'b1);
    quiet(6);
    i_mlic_core_model.do_return();
    take(ev(3, 1'b0), `MLIC_ACT_HIGH, 4'h3);
    set_req(3, 2'h0, 1'b0);
    repeat (3) i_mlic_core_model.do_return();
    @(negedge CORE_CLK);
    chk(ACTIVE_LEVELS === 4'h0, "all levels returned");
  endtask : t_preempt

  task automatic t_mask_nmi();
    LEVEL_EN = 3'h4;
    set_req(4, 2'h1, 1'b1);
    set_req(5, 2'h2, 1'b1);
    quiet(6);
    LEVEL_EN = 3'h0;
    set_req(3, 2'h3, 1'b1);
    quiet(3);
    BOOT_VECT_SEL = 1'b1;
    OSC_FAIL = 1'b1;
    take(`MLIC_BOOT_BASE + `MLIC_OSC_FAILURE_VECTOR, `MLIC_ACT_NMI, 4'h0);
    chk(ACTIVE_LEVELS[3] === 1'b1, "non-maskable level running");
    OSC_FAIL = 1'b0;
    BOOT_VECT_SEL = 1'b0;
    set_req(3, 2'h0, 1'b0);
    set_req(4, 2'h0, 1'b0);
    set_req(5, 2'h0, 1'b0);
    i_mlic_core_model.do_return();
    LEVEL_EN = 3'h7;
    quiet(4);
  endtask : t_mask_nmi

  // reset in mid-run with a high routine running and a low request pending
  task automatic t_reset();
    set_req(8, 2'h3, 1'b1);
    take(ev(8, 1'b0), `MLIC_ACT_HIGH, 4'h8);
    set_req(9, 2'h1, 1'b1);
    RST_B = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    chk(IRQ_VALID === 1'b0 && ACTIVE_LEVELS === 4'h0, "state after reset");
    chk(IRQ_VECTOR === '0 && IRQ_SRC === 4'h0 && IRQ_ACT_LEVEL === 2'h0, "outputs after reset");
    set_req(8, 2'h0, 1'b0);
    RST_B = 1'b1;
    take(ev(9, 1'b0), `MLIC_ACT_LOW, 4'h9);
    set_req(9, 2'h0, 1'b0);
    i_mlic_core_model.do_return();
  endtask : t_reset

  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    n_errors = 0;
    n_compared = 0;
    RST_B = 1'b0;
    RR_EN = 1'b0;
    BOOT_VECT_SEL = 1'b0;
    OSC_FAIL = 1'b0;
    IRQ_REQ = '0;
    IRQ_LEVEL = '0;
    for (int i = 0; i < 12; i++) IRQ_OFFSET[4*i +: 4] = 4'(i % 3 + 1);
    LEVEL_EN = 3'h7;
    ack_wait = 4'h0;
    repeat (4) @(negedge CORE_CLK);
    RST_B = 1'b1;
    t_round_robin();
    t_vectors();
    t_preempt();
    t_mask_nmi();
    t_reset();
    give_verdict();
  end

  // cuts a hang short well beyond the expected run length
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : tb_top
